/* design/smc_pkg.sv */
// Purpose: constants and types shared by the standby mode controller
// Assumes: apb slave with 32-bit data, one aligned word per register
// Notes:   every offset, single-bit field position, watchdog reset value and the state encoding live here
package smc_pkg;

    // ==========================================================
    // register map (byte addresses)
    localparam logic [7:0] LPCR_OFF  = 8'h00; // low_power_control_reg
    localparam logic [7:0] WDCS_OFF  = 8'h04; // watchdog_control_status
    localparam logic [7:0] WDCNT_OFF = 8'h08; // watchdog_counter
    localparam logic [7:0] WDRST_OFF = 8'h0c; // watchdog_reset_control_status
    localparam logic [7:0] ICR_OFF   = 8'h10; // interrupt_control_reg
    localparam logic [7:0] STAT_OFF  = 8'h14; // controller state, read only

    // ==========================================================
    // field positions and reset values
    localparam int         ARM_BIT       = 7; // standby_arm
    localparam int         FLOAT_BIT     = 6; // port_float_select
    localparam logic [5:0] LPCR_LOW_READ = 6'h1f; // bit 5 reads 0, bits 4-0 read 1
    localparam int         WD_OVF_BIT    = 7; // watchdog_overflow_flag
    localparam int         WD_MODE_BIT   = 6; // watchdog_interval_mode
    localparam int         WD_RUN_BIT    = 5; // watchdog_run
    localparam logic [7:0] WD_KEEP_MASK  = 8'h1f; // bits kept on standby entry
    localparam logic [7:0] WDCS_RESET    = 8'h00;
    localparam logic [7:0] WDCNT_RESET   = 8'h00;
    localparam logic [7:0] WDRST_RESET   = 8'h00;
    localparam logic [7:0] WDCNT_TOP     = 8'hff; // overflow on the next tick
    localparam int         POL_BIT       = 0; // nmi_edge_polarity, 1 = rising

    // ==========================================================
    // controller states
    typedef enum logic [3:0] {
        ST_RUN    = 4'b0001,
        ST_SLEEP  = 4'b0010,
        ST_STBY   = 4'b0100,
        ST_SETTLE = 4'b1000
    } smc_state_e;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic [7:0]  paddr;
        logic        pwrite;
        logic [31:0] pwdata;
        logic        psel;
        logic        penable;
    } smc_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } smc_apb_rsp_s;

    typedef struct packed {
        logic cpu_halt;    // cpu stopped
        logic clk_stop;    // system clock stopped
        logic periph_halt; // on-chip peripherals halted
        logic wdt_clk_en;  // watchdog receives clock
        logic port_float;  // io ports high impedance
        logic port_hold;   // io ports hold prior state
        logic reg_hold;    // cpu registers and ram frozen
    } smc_ctl_s;

    typedef struct packed {
        logic dma;
        logic timer;
        logic adc;
        logic serial;
    } smc_init_s;

    typedef struct packed {
        logic nmi_exc; // begin nmi exception handling
        logic por_req; // enter power-on reset state
        logic man_req; // enter manual reset state
    } smc_evt_s;

    typedef struct packed {
        smc_state_e   state;
        logic         arm;
        logic         float_sel;
        logic         pol;
        logic [7:0]   wdcs;
        logic [7:0]   wdcnt;
        logic [7:0]   wdrst;
        logic [15:0]  presc;
        logic         nmi_prev;
        logic         rstn_prev;
        smc_apb_rsp_s rsp;
        smc_ctl_s     ctl;
        smc_init_s    init;
        smc_evt_s     evt;
    } smc_regs_s;

endpackage

/* design/smc_top.sv */
// Purpose: standby mode controller with watchdog-timed wake and reset exits
// Assumes: pins and sleep_exec synchronous to pclk; apb slave, one wait state
// Notes:   all state is one packed struct registered once
//
// Implementation choices: the register addresses and the APB interface to the registers.
module smc_top (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire smc_pkg::smc_apb_req_s apb_req,
    output smc_pkg::smc_apb_rsp_s      apb_rsp,
    input  wire logic                 sleep_exec,
    input  wire logic                 nmi_pin,
    input  wire logic                 reset_pin_n,
    output smc_pkg::smc_ctl_s          ctl,
    output smc_pkg::smc_init_s         init,
    output smc_pkg::smc_evt_s          evt
);

    // ==========================================================
    // state register and reset value
    localparam smc_pkg::smc_regs_s RST_VAL = '{
        state:     smc_pkg::ST_RUN,
        arm:       1'b0,
        float_sel: 1'b0,
        pol:       1'b0,
        wdcs:      smc_pkg::WDCS_RESET,
        wdcnt:     smc_pkg::WDCNT_RESET,
        wdrst:     smc_pkg::WDRST_RESET,
        presc:     16'h0000,
        nmi_prev:  1'b0,
        rstn_prev: 1'b1,
        rsp:       '0,
        ctl:       '0,
        init:      '0,
        evt:       '0
    };

    smc_pkg::smc_regs_s s_q;
    smc_pkg::smc_regs_s s_d;

    logic        nmi_edge;
    logic        rst_fall;
    logic        wdt_tick;
    logic        access;
    logic        commit;
    logic        mapped;
    logic [15:0] tick_mask;
    logic [31:0] rdata;

    // ==========================================================
    // pin edge detection and watchdog prescaler tick
    always_comb begin
        // selected edge; rising only when polarity bit is one
        nmi_edge  = s_q.pol ? (nmi_pin & ~s_q.nmi_prev) : (~nmi_pin & s_q.nmi_prev);
        rst_fall  = ~reset_pin_n & s_q.rstn_prev;
        tick_mask = 16'((16'h0002 << {s_q.wdcs[2:0], 1'b0}) - 16'h0001);
        wdt_tick  = (s_q.presc & tick_mask) == tick_mask;
    end

    // ==========================================================
    // apb decode and read mux
    always_comb begin
        access = apb_req.psel & apb_req.penable;
        commit = access & s_q.rsp.pready; // edge where master samples pready
        mapped = 1'b1;
        rdata  = 32'h0000_0000;
        case (apb_req.paddr)
            smc_pkg::LPCR_OFF:  rdata = {24'h000000, s_q.arm, s_q.float_sel,
                                         smc_pkg::LPCR_LOW_READ};
            smc_pkg::WDCS_OFF:  rdata = {24'h000000, s_q.wdcs};
            smc_pkg::WDCNT_OFF: rdata = {24'h000000, s_q.wdcnt};
            smc_pkg::WDRST_OFF: rdata = {24'h000000, s_q.wdrst};
            smc_pkg::ICR_OFF:   rdata = {31'h00000000, s_q.pol};
            smc_pkg::STAT_OFF:  rdata = {28'h0000000, s_q.state};
            default:            mapped = 1'b0;
        endcase
    end

    // ==========================================================
    // next state
    always_comb begin
        s_d           = s_q;
        s_d.evt       = '0;
        s_d.init      = '0;
        s_d.nmi_prev  = nmi_pin;
        s_d.rstn_prev = reset_pin_n;

        // bus answer one cycle into the access phase
        s_d.rsp.pready = access & ~s_q.rsp.pready;
        if (access & ~s_q.rsp.pready) begin
            s_d.rsp.prdata  = apb_req.pwrite ? 32'h0000_0000 : rdata;
            s_d.rsp.pslverr = ~mapped;
        end

        // register writes
        if (commit & apb_req.pwrite) begin
            case (apb_req.paddr)
                smc_pkg::LPCR_OFF: begin
                    if (!s_q.wdcs[smc_pkg::WD_RUN_BIT]) begin
                        s_d.arm       = apb_req.pwdata[smc_pkg::ARM_BIT];
                        s_d.float_sel = apb_req.pwdata[smc_pkg::FLOAT_BIT];
                    end
                end
                smc_pkg::WDCS_OFF: begin
                    // software can clear the overflow flag but never set it
                    s_d.wdcs = {s_q.wdcs[smc_pkg::WD_OVF_BIT] & apb_req.pwdata[7],
                                apb_req.pwdata[6:0]};
                end
                smc_pkg::WDCNT_OFF: s_d.wdcnt = apb_req.pwdata[7:0];
                smc_pkg::WDRST_OFF: s_d.wdrst = apb_req.pwdata[7:0];
                smc_pkg::ICR_OFF:   s_d.pol   = apb_req.pwdata[smc_pkg::POL_BIT];
                default: ;
            endcase
        end

        // prescaler runs whenever the watchdog is clocked
        s_d.presc = s_q.ctl.wdt_clk_en ? s_q.presc + 16'h0001 : 16'h0000;

        case (s_q.state)
            smc_pkg::ST_RUN: begin
                // free running watchdog; overflow set wins over a clear
                if (s_q.wdcs[smc_pkg::WD_RUN_BIT] && wdt_tick) begin
                    s_d.wdcnt = s_q.wdcnt + 8'h01;
                    if (s_q.wdcnt == smc_pkg::WDCNT_TOP) begin
                        s_d.wdcs[smc_pkg::WD_OVF_BIT] = 1'b1;
                    end
                end
                if (sleep_exec) begin
                    if (s_q.arm) begin
                        s_d.state = smc_pkg::ST_STBY;
                        s_d.wdcs  = s_d.wdcs & smc_pkg::WD_KEEP_MASK;
                        s_d.wdrst = smc_pkg::WDRST_RESET;
                        s_d.init  = '1;
                        // control register and other units untouched
                    end else begin
                        s_d.state = smc_pkg::ST_SLEEP;
                    end
                end
            end
            smc_pkg::ST_SLEEP: begin
                if (nmi_edge) begin
                    s_d.state       = smc_pkg::ST_RUN;
                    s_d.evt.nmi_exc = 1'b1;
                end
            end
            smc_pkg::ST_STBY: begin
                if (nmi_edge) begin
                    s_d.state = smc_pkg::ST_SETTLE;
                    s_d.presc = 16'h0000;
                end
            end
            smc_pkg::ST_SETTLE: begin
                // counter continues from its kept value until overflow
                if (wdt_tick) begin
                    s_d.wdcnt = s_q.wdcnt + 8'h01;
                    if (s_q.wdcnt == smc_pkg::WDCNT_TOP) begin
                        s_d.state       = smc_pkg::ST_RUN;
                        s_d.evt.nmi_exc = 1'b1;
                    end
                end
            end
            default: s_d.state = smc_pkg::ST_RUN;
        endcase

        // reset pin wins over every other exit
        if (rst_fall) begin
            s_d.state       = smc_pkg::ST_RUN;
            s_d.evt.nmi_exc = 1'b0;
            s_d.evt.por_req = nmi_pin;
            s_d.evt.man_req = ~nmi_pin;
        end

        // control outputs follow the next state
        s_d.ctl.cpu_halt    = s_d.state != smc_pkg::ST_RUN;
        s_d.ctl.clk_stop    = s_d.state inside {smc_pkg::ST_STBY, smc_pkg::ST_SETTLE};
        s_d.ctl.periph_halt = s_d.ctl.clk_stop;
        s_d.ctl.wdt_clk_en  = s_d.state != smc_pkg::ST_STBY;
        s_d.ctl.port_float  = s_d.ctl.clk_stop & s_d.float_sel;
        s_d.ctl.port_hold   = s_d.ctl.clk_stop & ~s_d.float_sel;
        s_d.ctl.reg_hold    = s_d.ctl.clk_stop;
    end

    // registers the whole state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= RST_VAL;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // outputs straight from the state register
    assign apb_rsp = s_q.rsp;
    assign ctl     = s_q.ctl;
    assign init    = s_q.init;
    assign evt     = s_q.evt;

    // ==========================================================
    // checks
    arm_refused_a: assert property (@(posedge pclk) disable iff (!presetn)
        commit && apb_req.pwrite && apb_req.paddr == smc_pkg::LPCR_OFF
        && s_q.wdcs[smc_pkg::WD_RUN_BIT] |=> $stable(s_q.arm))
        else $error("standby arm changed while watchdog running");

    standby_halt_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.state == smc_pkg::ST_STBY |-> ctl.cpu_halt && ctl.clk_stop
        && ctl.periph_halt && !ctl.wdt_clk_en)
        else $error("standby without full halt");

    hold_ram_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.state == smc_pkg::ST_STBY |-> ctl.reg_hold)
        else $error("registers not held in standby");

    port_state_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.state == smc_pkg::ST_STBY |-> ctl.port_float == s_q.float_sel
        && ctl.port_hold == !s_q.float_sel)
        else $error("port state disagrees with float select");

    entry_init_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.state == smc_pkg::ST_RUN && sleep_exec && s_q.arm && !rst_fall
        |=> init == '1 ##1 init == '0)
        else $error("unit init pulse missing on entry");

    wdt_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.state == smc_pkg::ST_RUN && sleep_exec && s_q.arm && !rst_fall
        && !(commit && apb_req.pwrite)
        |=> s_q.wdcs[7:5] == 3'b000 && s_q.wdrst == 8'h00
        && s_q.wdcs[2:0] == $past(s_q.wdcs[2:0]) && $stable(s_q.arm))
        else $error("watchdog fields wrong after entry");

    settle_exit_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.state == smc_pkg::ST_SETTLE && wdt_tick && !rst_fall
        && s_q.wdcnt == smc_pkg::WDCNT_TOP
        |=> s_q.state == smc_pkg::ST_RUN && evt.nmi_exc && !ctl.cpu_halt)
        else $error("no resume on watchdog overflow");

    settle_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.state == smc_pkg::ST_STBY && nmi_edge && !rst_fall
        |=> s_q.state == smc_pkg::ST_SETTLE && ctl.wdt_clk_en && ctl.clk_stop)
        else $error("nmi edge did not start watchdog settle");

    por_exit_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.state == smc_pkg::ST_STBY && rst_fall && nmi_pin
        |=> evt.por_req && !evt.man_req && s_q.state == smc_pkg::ST_RUN)
        else $error("power-on reset exit missing");

    man_exit_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.state == smc_pkg::ST_STBY && rst_fall && !nmi_pin
        |=> evt.man_req && !evt.por_req && s_q.state == smc_pkg::ST_RUN)
        else $error("manual reset exit missing");

    // sleep with the arm bit clear halts only the cpu and inits nothing
    sleep_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.state == smc_pkg::ST_RUN && sleep_exec && !s_q.arm && !rst_fall
        |=> s_q.state == smc_pkg::ST_SLEEP && init == '0 && ctl.cpu_halt
        && !ctl.clk_stop && ctl.wdt_clk_en)
        else $error("sleep entry wrong");

    // selected nmi edge ends sleep with an nmi exception
    sleep_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.state == smc_pkg::ST_SLEEP && nmi_edge && !rst_fall
        |=> s_q.state == smc_pkg::ST_RUN && evt.nmi_exc)
        else $error("sleep not ended by nmi edge");

    // float select is refused like the arm bit while the watchdog runs
    float_refused_a: assert property (@(posedge pclk) disable iff (!presetn)
        commit && apb_req.pwrite && apb_req.paddr == smc_pkg::LPCR_OFF
        && s_q.wdcs[smc_pkg::WD_RUN_BIT] |=> $stable(s_q.float_sel))
        else $error("float select changed while watchdog running");

    // no exit from standby without an nmi edge or a reset pin fall
    stby_stays_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.state == smc_pkg::ST_STBY && !nmi_edge && !rst_fall
        |=> s_q.state == smc_pkg::ST_STBY)
        else $error("standby left without an exit event");

    // control register untouched by standby itself
    lpcr_kept_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.state == smc_pkg::ST_STBY && !(commit && apb_req.pwrite)
        |=> $stable(s_q.arm) && $stable(s_q.float_sel))
        else $error("control register changed in standby");

    // watchdog counter and clock select frozen while the watchdog clock is stopped
    wdt_frozen_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.state == smc_pkg::ST_STBY && !(commit && apb_req.pwrite)
        |=> $stable(s_q.wdcnt) && $stable(s_q.wdcs[2:0]))
        else $error("watchdog count or select lost in standby");

endmodule

/* tb/smc_partner.sv */
// Purpose: cpu software and pin model on the far side of the standby controller
// Assumes: every pin changes just after a rising pclk edge
// Notes:   nmi and reset pins idle high; sleep is a one-cycle pulse
module smc_partner (
    input  wire logic pclk,
    output logic      sleep_exec,
    output logic      nmi_pin,
    output logic      reset_pin_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // pin levels at time zero
    initial begin
        sleep_exec  = 1'b0;
        nmi_pin     = 1'b1;
        reset_pin_n = 1'b1;
    end

    // sleep instruction, issued only after the arm bit was written
    task automatic sleep_pulse();
        @(posedge pclk);
        sleep_exec <= 1'b1;
        @(posedge pclk);
        sleep_exec <= 1'b0;
    endtask

    // nmi level, changed after sleep entry to drive the edge under test
    task automatic set_nmi(input logic v);
        @(posedge pclk);
        nmi_pin <= v;
    endtask

    // reset pin level, a falling edge requests a reset exit
    task automatic set_rst(input logic v);
        @(posedge pclk);
        reset_pin_n <= v;
    endtask
endmodule

/* tb/tb.sv */
// Purpose: self-checking bench for the standby mode controller
// Assumes: apb master waits for pready; partner drives the pins
// Notes:   register rows first, then standby entry and exit cases
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] data;
        logic [31:0] exp;
        logic        err;
    } smc_row_s;

    logic                  pclk;
    logic                  presetn;
    smc_pkg::smc_apb_req_s apb_req;
    smc_pkg::smc_apb_rsp_s apb_rsp;
    logic                  sleep_exec;
    logic                  nmi_pin;
    logic                  reset_pin_n;
    smc_pkg::smc_ctl_s     ctl;
    smc_pkg::smc_init_s    init;
    smc_pkg::smc_evt_s     evt;
    int                    n_mismatch;
    int                    samples_checked;
    int                    n;
    logic [31:0]           rdv;
    logic                  erv;
    smc_row_s              rows [11] = '{
        '{1'b0, 8'h00, 32'h0, 32'h1f, 1'b0}, '{1'b0, 8'h04, 32'h0, 32'h00, 1'b0},
        '{1'b0, 8'h08, 32'h0, 32'h00, 1'b0}, '{1'b0, 8'h0c, 32'h0, 32'h00, 1'b0},
        '{1'b0, 8'h10, 32'h0, 32'h00, 1'b0}, '{1'b0, 8'h14, 32'h0, 32'h01, 1'b0},
        '{1'b1, 8'h00, 32'h80, 32'h9f, 1'b0}, '{1'b1, 8'h00, 32'hffff_ff7f, 32'h5f, 1'b0},
        '{1'b1, 8'h10, 32'h01, 32'h01, 1'b0}, '{1'b1, 8'h10, 32'h00, 32'h00, 1'b0},
        '{1'b1, 8'hf8, 32'h5a, 32'h00, 1'b1}};

    smc_top u_smc_top (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .sleep_exec(sleep_exec), .nmi_pin(nmi_pin), .reset_pin_n(reset_pin_n), .ctl(ctl),
        .init(init), .evt(evt));
    smc_partner u_smc_partner (.pclk(pclk), .sleep_exec(sleep_exec), .nmi_pin(nmi_pin),
        .reset_pin_n(reset_pin_n));

    // ==========================================================
    // clock and watchdog
    always #2.5 pclk = ~pclk;

    initial begin
        #100us;
        n_mismatch++;
        conclude();
    end

    // ==========================================================
    // helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        apb_req <= '{paddr: a, pwrite: w, pwdata: d, psel: 1'b1, penable: 1'b0};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (apb_rsp.pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            // a slave that never answers ends the run as a failure
            n_mismatch++;
            conclude();
        end
        rdv = apb_rsp.prdata;
        erv = apb_rsp.pslverr;
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    // sleep with the arm bit set, then look at the entry outputs
    task automatic enter(input logic [6:0] exp_ctl);
        u_smc_partner.sleep_pulse();
        #1;
        chk({25'h0, ctl}, {25'h0, exp_ctl});
        chk({28'h0, init}, 32'hf);
        @(posedge pclk);
        #1;
        chk({28'h0, init}, 32'h0);
    endtask

    task automatic wait_wake();
        n = 0;
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while (evt.nmi_exc !== 1'b1 && n < 300);
        chk({29'h0, evt}, 32'h4);
        chk({25'h0, ctl}, 32'h08);
    endtask

    task automatic pin_reset(input logic [31:0] exp_evt);
        u_smc_partner.set_rst(1'b0);
        @(posedge pclk);
        #1;
        chk({29'h0, evt}, exp_evt);
        chk({25'h0, ctl}, 32'h08);
        u_smc_partner.set_rst(1'b1);
    endtask

    task automatic conclude();
        if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        apb_req = '0;
        n_mismatch = 0;
        samples_checked = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values and plain register accesses
        foreach (rows[i]) begin
            if (rows[i].wr) apb(1'b1, rows[i].addr, rows[i].data);
            apb(1'b0, rows[i].addr, 32'h0);
            chk(rdv, rows[i].exp);
            chk({31'h0, erv}, {31'h0, rows[i].err});
        end
        // arm refused while the watchdog runs
        apb(1'b1, 8'h04, 32'h20);
        apb(1'b1, 8'h00, 32'h80);
        apb(1'b0, 8'h00, 32'h0);
        chk(rdv, 32'h5f);
        apb(1'b1, 8'h04, 32'h00);
        // falling-edge wake, interval select 1 and mode bit set beforehand
        apb(1'b1, 8'h08, 32'hfe);
        apb(1'b1, 8'h04, 32'h41);
        apb(1'b1, 8'h00, 32'hc0);
        enter(7'h75);
        u_smc_partner.set_nmi(1'b0);
        @(posedge pclk);
        #1;
        chk({30'h0, ctl.clk_stop, ctl.wdt_clk_en}, 32'h3);
        wait_wake();
        chk({31'h0, n >= 16}, 32'h1);
        apb(1'b0, 8'h04, 32'h0);
        chk(rdv, 32'h01);
        apb(1'b0, 8'h0c, 32'h0);
        chk(rdv, 32'h00);
        apb(1'b0, 8'h00, 32'h0);
        chk(rdv, 32'hdf);
        // back into standby with nmi low, then a manual reset exit
        enter(7'h75);
        pin_reset(32'h1);
        // rising nmi with falling selected must not wake, then power-on reset
        apb(1'b1, 8'h00, 32'h80);
        apb(1'b1, 8'h08, 32'hfe);
        enter(7'h73);
        u_smc_partner.set_nmi(1'b1);
        repeat (20) begin
            @(posedge pclk);
            #1;
            chk({28'h0, ctl.cpu_halt, evt}, 32'h8);
        end
        pin_reset(32'h2);
        // falling nmi wakes from standby after the power-on reset exit
        apb(1'b1, 8'h08, 32'hfe);
        enter(7'h73);
        u_smc_partner.set_nmi(1'b0);
        wait_wake();
        // rising edge selected by the handler, then rising wake
        apb(1'b1, 8'h10, 32'h01);
        apb(1'b1, 8'h08, 32'hfe);
        enter(7'h73);
        u_smc_partner.set_nmi(1'b1);
        wait_wake();
        apb(1'b0, 8'h00, 32'h0);
        chk(rdv, 32'h9f);
        // sleep mode with the arm bit clear, falling nmi wakes it
        apb(1'b1, 8'h00, 32'h00);
        apb(1'b1, 8'h10, 32'h00);
        u_smc_partner.sleep_pulse();
        #1;
        chk({25'h0, ctl}, 32'h48);
        chk({28'h0, init}, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk(rdv, 32'h02);
        u_smc_partner.set_nmi(1'b0);
        @(posedge pclk);
        #1;
        chk({29'h0, evt}, 32'h4);
        chk({25'h0, ctl}, 32'h08);
        // mid-run reset brings the control register back to its reset value
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        chk(rdv, 32'h1f);
        apb(1'b0, 8'h14, 32'h0);
        chk(rdv, 32'h01);
        conclude();
    end
endmodule
